// file: hdl/out_one_cfg_pkg.sv
// Purpose: Shared constants and types for the output channel one configuration registers
// Assumes: 8-bit register port, byte addresses as printed
// Notes: Field positions are given as low bit and width

package out_one_cfg_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned NUM_REGS = 2;

  // Register offsets
  localparam logic [ADDR_W-1:0] OUTPUT_ONE_SOURCE_ROUTE_OFS = 8'h64;
  localparam logic [ADDR_W-1:0] OUTPUT_ONE_DRIVE_LEVEL_OFS = 8'h65;

  // Reset values
  localparam logic [DATA_W-1:0] OUTPUT_ONE_SOURCE_ROUTE_RST = 8'h20;
  localparam logic [DATA_W-1:0] OUTPUT_ONE_DRIVE_LEVEL_RST = 8'h20;
  localparam logic [DATA_W-1:0] UNMAPPED_RDATA = 8'h00;

  // First register field positions
  localparam int unsigned SRC_LSB = 5;
  localparam int unsigned SRC_W = 3;
  localparam int unsigned ROUTE_LSB = 2;
  localparam int unsigned ROUTE_W = 3;
  localparam int unsigned VCOM_BIT = 1;
  localparam int unsigned LP_BIT = 0;

  // Second register field positions
  localparam int unsigned DRIVE_LSB = 6;
  localparam int unsigned DRIVE_W = 2;
  localparam int unsigned LVL_LSB = 3;
  localparam int unsigned LVL_W = 3;
  localparam int unsigned IMP_BIT = 2;
  localparam int unsigned TOPO_BIT = 1;
  localparam int unsigned BW_BIT = 0;

  // Level steps: code 0 is +24 dB, each code 6 dB lower
  localparam logic signed [7:0] LEVEL_TOP_DB = 8'sh18;
  localparam logic signed [7:0] LEVEL_STEP_DB = 8'sh06;
  localparam logic [2:0] LEVEL_RESERVED = 3'h7;

  typedef enum logic [2:0] {
    SRC_OFF,
    SRC_CONVERTER,
    SRC_BYPASS,
    SRC_MIXED,
    SRC_SPLIT_CONV_POS,
    SRC_SPLIT_BYP_POS,
    SRC_RSVD_6,
    SRC_RSVD_7
  } chan_one_source_select_t;

  typedef enum logic [2:0] {
    ROUTE_DIFF,
    ROUTE_STEREO_SE,
    ROUTE_MONO_POS,
    ROUTE_MONO_NEG,
    ROUTE_PSEUDO_NEG_VCOM,
    ROUTE_PSEUDO_NEG_VCOM_SENSE,
    ROUTE_PSEUDO_POS_VCOM,
    ROUTE_RSVD_7
  } chan_one_routing_t;

  typedef enum logic [1:0] {
    DRV_LINE,
    DRV_HEADPHONE,
    DRV_FOUR_OHM,
    DRV_RECEIVER_DEBUG
  } pos_pin_driver_type_t;

  // Fields of the first register, in bit order
  typedef struct packed {
    chan_one_source_select_t chan_one_source_select;
    chan_one_routing_t chan_one_routing;
    logic chan_one_common_mode_sel;
    logic chan_one_low_power;
  } source_route_t;

  // Fields of the second register, in bit order
  typedef struct packed {
    pos_pin_driver_type_t pos_pin_driver_type;
    logic [2:0] pos_pin_level;
    logic neg_bypass_input_impedance;
    logic bypass_input_topology;
    logic converter_one_bandwidth;
  } drive_level_t;

  // Decoded steering toward the analog output stage
  typedef struct packed {
    logic driver_enable;
    logic converter_path;
    logic bypass_path;
    logic split_mode;
    logic signed [7:0] pos_level_db;
    logic routing_conflict;
    logic low_power_conflict;
    logic reserved_code;
  } steer_t;

endpackage : out_one_cfg_pkg

// file: hdl/cfg_byte_reg.sv
// Purpose: One read/write configuration byte with a constant reset value
// Assumes: Synchronous active-low reset, write strobe synchronous to clk_i
// Notes: No side effects on write beyond storing the byte

`timescale 1ns/100ps
`default_nettype none

module cfg_byte_reg #(
  parameter int unsigned WIDTH = 8,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic wr_en_i,
  input wire logic [WIDTH-1:0] wdata_i,
  output logic [WIDTH-1:0] value_o
);

  logic [WIDTH-1:0] value_q;
  logic [WIDTH-1:0] value_d;

  // Hold unless written; every bit is writable
  assign value_d = wr_en_i ? wdata_i : value_q;

  // Reset takes the constant only
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      value_q <= RESET_VALUE;
    end else begin
      value_q <= value_d;
    end
  end

  assign value_o = value_q;

endmodule // cfg_byte_reg

`default_nettype wire

// file: hdl/output_channel_one_config_regs.sv
// Purpose: Configuration bank for output channel one (source, routing, drive, level, bypass, bandwidth)
// Assumes: Simple synchronous register port; one access per cycle; 250 MHz clock
// Notes: Fields leave as flops; decoded steering and misuse flags are combinational from flops

`timescale 1ns/100ps
`default_nettype none

module output_channel_one_config_regs
  import out_one_cfg_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [DATA_W-1:0] reg_wdata_i,
  output logic [DATA_W-1:0] reg_rdata_o,
  output logic reg_rvalid_o,
  output source_route_t source_route_o,
  output drive_level_t drive_level_o,
  output steer_t steer_o
);

  // Address map and reset values, indexed by register number
  localparam logic [ADDR_W-1:0] REG_OFS [NUM_REGS] = '{OUTPUT_ONE_SOURCE_ROUTE_OFS, OUTPUT_ONE_DRIVE_LEVEL_OFS};
  localparam logic [DATA_W-1:0] REG_RST [NUM_REGS] = '{OUTPUT_ONE_SOURCE_ROUTE_RST, OUTPUT_ONE_DRIVE_LEVEL_RST};

  logic [NUM_REGS-1:0] hit;
  logic [DATA_W-1:0] reg_val [NUM_REGS];
  logic [DATA_W-1:0] rd_mux;
  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] rdata_d;
  logic rvalid_q;
  source_route_t source_route;
  drive_level_t drive_level;
  logic signed [7:0] level_drop;
  logic split_src;

  // One storage byte per register; a write lands only on its own offset
  for (genvar i = 0; i < NUM_REGS; i++) begin : g_reg
    assign hit[i] = (reg_addr_i == REG_OFS[i]);

    cfg_byte_reg #(
      .WIDTH(DATA_W),
      .RESET_VALUE(REG_RST[i])
    ) u_byte (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .wr_en_i(reg_wr_i && hit[i]),
      .wdata_i(reg_wdata_i),
      .value_o(reg_val[i])
    );
  end

  // Read select; unmapped offsets answer zero rather than aliasing
  assign rd_mux = hit[0] ? reg_val[0] : (hit[1] ? reg_val[1] : UNMAPPED_RDATA);
  assign rdata_d = reg_rd_i ? rd_mux : rdata_q;

  // Read data is held in a flop so the port sees a clean value one cycle after the strobe
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rdata_q <= '0;
      rvalid_q <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      rvalid_q <= reg_rd_i;
    end
  end

  assign reg_rdata_o = rdata_q;
  assign reg_rvalid_o = rvalid_q;

  // Field split of the first register
  assign source_route.chan_one_source_select =
    chan_one_source_select_t'(reg_val[0][SRC_LSB +: SRC_W]);
  assign source_route.chan_one_routing = chan_one_routing_t'(reg_val[0][ROUTE_LSB +: ROUTE_W]);
  assign source_route.chan_one_common_mode_sel = reg_val[0][VCOM_BIT];
  assign source_route.chan_one_low_power = reg_val[0][LP_BIT];

  // Field split of the second register
  assign drive_level.pos_pin_driver_type = pos_pin_driver_type_t'(reg_val[1][DRIVE_LSB +: DRIVE_W]);
  assign drive_level.pos_pin_level = reg_val[1][LVL_LSB +: LVL_W];
  assign drive_level.neg_bypass_input_impedance = reg_val[1][IMP_BIT];
  assign drive_level.bypass_input_topology = reg_val[1][TOPO_BIT];
  assign drive_level.converter_one_bandwidth = reg_val[1][BW_BIT];

  assign source_route_o = source_route;
  assign drive_level_o = drive_level;

  // Path decode from the source select; reserved codes keep the driver off for safety
  assign split_src = (source_route.chan_one_source_select == SRC_SPLIT_CONV_POS) ||
                     (source_route.chan_one_source_select == SRC_SPLIT_BYP_POS);
  assign steer_o.driver_enable = (source_route.chan_one_source_select != SRC_OFF) &&
                                 (source_route.chan_one_source_select != SRC_RSVD_6) &&
                                 (source_route.chan_one_source_select != SRC_RSVD_7);
  assign steer_o.converter_path = (source_route.chan_one_source_select == SRC_CONVERTER) ||
                                  (source_route.chan_one_source_select == SRC_MIXED) || split_src;
  assign steer_o.bypass_path = (source_route.chan_one_source_select == SRC_BYPASS) ||
                               (source_route.chan_one_source_select == SRC_MIXED) || split_src;
  assign steer_o.split_mode = split_src;

  // Level in dB: 24 minus 6 per code; product fits in 8 bits for codes 0..7
  assign level_drop = 8'(signed'({5'h00, drive_level.pos_pin_level}) * LEVEL_STEP_DB);
  assign steer_o.pos_level_db = 8'(LEVEL_TOP_DB - level_drop);

  // Misuse indicators: the device stores what software wrote, these only report it
  assign steer_o.routing_conflict = split_src &&
                                    (source_route.chan_one_routing != ROUTE_DIFF);
  assign steer_o.low_power_conflict = source_route.chan_one_low_power &&
    ((source_route.chan_one_source_select != SRC_CONVERTER) ||
     (source_route.chan_one_routing == ROUTE_STEREO_SE));
  assign steer_o.reserved_code = (source_route.chan_one_source_select == SRC_RSVD_6) ||
                                 (source_route.chan_one_source_select == SRC_RSVD_7) ||
                                 (source_route.chan_one_routing == ROUTE_RSVD_7) ||
                                 (drive_level.pos_pin_level == LEVEL_RESERVED);

endmodule // output_channel_one_config_regs

`default_nettype wire

// file: dv/out_one_cfg_asserts.sv
// Purpose: Port checker for the output channel one configuration bank
// Assumes: One clock, synchronous active-low reset
// Notes: Sees only the top module ports
`timescale 1ns/100ps
`default_nettype none
module out_one_cfg_chk
  import out_one_cfg_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [DATA_W-1:0] reg_wdata_i,
  input wire logic [DATA_W-1:0] reg_rdata_o,
  input wire logic reg_rvalid_o,
  input wire source_route_t source_route_o,
  input wire drive_level_t drive_level_o,
  input wire steer_t steer_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // Address decodes for the two bytes
  wire sel_a = reg_addr_i == OUTPUT_ONE_SOURCE_ROUTE_OFS;
  wire sel_b = reg_addr_i == OUTPUT_ONE_DRIVE_LEVEL_OFS;
  AST_RST: assert property (disable iff (1'b0) !rst_n_i |=> source_route_o == 8'h20 && drive_level_o == 8'h20)
    else $error("reset value wrong");
  AST_WR_A: assert property (reg_wr_i && sel_a |=> source_route_o == $past(reg_wdata_i))
    else $error("first byte not written");
  AST_WR_B: assert property (reg_wr_i && sel_b |=> drive_level_o == $past(reg_wdata_i))
    else $error("second byte not written");
  AST_KEEP_A: assert property (!(reg_wr_i && sel_a) |=> $stable(source_route_o))
    else $error("first byte changed");
  AST_KEEP_B: assert property (!(reg_wr_i && sel_b) |=> $stable(drive_level_o))
    else $error("second byte changed");
  AST_RVALID: assert property (1'b1 |=> reg_rvalid_o == $past(reg_rd_i))
    else $error("read valid wrong");
  AST_RD_A: assert property (reg_rd_i && sel_a |=> reg_rdata_o == $past(source_route_o))
    else $error("first byte read wrong");
  AST_RD_B: assert property (reg_rd_i && sel_b |=> reg_rdata_o == $past(drive_level_o))
    else $error("second byte read wrong");
  AST_RD_U: assert property (reg_rd_i && !sel_a && !sel_b |=> reg_rdata_o == UNMAPPED_RDATA)
    else $error("unmapped read wrong");
  AST_LVL: assert property (steer_o.pos_level_db == 8'sh18 - 8'sh06 * signed'({5'h00, drive_level_o.pos_pin_level}))
    else $error("level decode wrong");
  AST_DRV: assert property (steer_o.driver_enable == (source_route_o[7:5] inside {[3'h1:3'h5]}))
    else $error("driver enable wrong");
endmodule // out_one_cfg_chk
bind output_channel_one_config_regs out_one_cfg_chk u_chk (.clk_i(clk_i), .rst_n_i(rst_n_i),
  .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
  .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o), .source_route_o(source_route_o),
  .drive_level_o(drive_level_o), .steer_o(steer_o));
`default_nettype wire

// file: dv/output_channel_one_config_regs_tb_top.sv
// Purpose: Self-checking bench for the output channel one configuration bank
// Assumes: Strobes driven at the falling edge
// Notes: Reset values are read first; rows write a byte and read it back; a mid-run reset follows
`timescale 1ns/100ps
`default_nettype none
module output_channel_one_config_regs_tb_top import out_one_cfg_pkg::*;
;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00;
  logic [7:0] reg_wdata_i = 8'h00;
  logic [7:0] reg_rdata_o;
  logic reg_rvalid_o;
  source_route_t source_route_o;
  drive_level_t drive_level_o;
  steer_t steer_o;
  int err_total = 0;
  int check_count = 0;
  // Steering outputs grouped the way the rows hold them
  wire [3:0] path_seen = {steer_o.driver_enable, steer_o.converter_path, steer_o.bypass_path, steer_o.split_mode};
  wire [2:0] flags_seen = {steer_o.routing_conflict, steer_o.low_power_conflict, steer_o.reserved_code};
  // One case: offset, write data, readback, then the steering it leaves behind
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic [3:0] path;
    logic [7:0] level_db;
    logic [2:0] flags;
  } row_t;
  // Path is enable, converter, bypass, split; flags are routing, low power, reserved
  // Misuse rows break the software rules on purpose so the flags must rise; unmapped offsets read zero
  row_t rows [15] = '{
    '{8'h64, 8'h00, 8'h00, 4'h0, 8'h00, 3'h0},
    '{8'h64, 8'h40, 8'h40, 4'ha, 8'h00, 3'h0},
    '{8'h64, 8'h60, 8'h60, 4'he, 8'h00, 3'h0},
    '{8'h64, 8'h84, 8'h84, 4'hf, 8'h00, 3'h4},
    '{8'h64, 8'ha3, 8'ha3, 4'hf, 8'h00, 3'h2},
    '{8'h64, 8'hc2, 8'hc2, 4'h0, 8'h00, 3'h1},
    '{8'h64, 8'hfd, 8'hfd, 4'h0, 8'h00, 3'h3},
    '{8'h64, 8'h25, 8'h25, 4'hc, 8'h00, 3'h2},
    '{8'h64, 8'h21, 8'h21, 4'hc, 8'h00, 3'h0},
    '{8'h65, 8'h00, 8'h00, 4'hc, 8'h18, 3'h0},
    '{8'h65, 8'h5b, 8'h5b, 4'hc, 8'h06, 3'h0},
    '{8'h65, 8'hb4, 8'hb4, 4'hc, 8'hf4, 3'h0},
    '{8'h65, 8'hf9, 8'hf9, 4'hc, 8'hee, 3'h1},
    '{8'h66, 8'h55, 8'h00, 4'hc, 8'hee, 3'h1},
    '{8'h63, 8'haa, 8'h00, 4'hc, 8'hee, 3'h1}};
  output_channel_one_config_regs u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .reg_rvalid_o(reg_rvalid_o), .source_route_o(source_route_o), .drive_level_o(drive_level_o),
    .steer_o(steer_o));
  // Clock, 4 ns period
  initial begin
    forever #2 clk_i = ~clk_i;
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    reg_wr_i = 1'b1;
    reg_addr_i = a;
    reg_wdata_i = d;
    @(negedge clk_i);
    reg_wr_i = 1'b0;
  endtask
  // Read pulse; data and valid are due one cycle later
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk_i);
    reg_rd_i = 1'b1;
    reg_addr_i = a;
    @(negedge clk_i);
    reg_rd_i = 1'b0;
    chk({7'h00, reg_rvalid_o}, 8'h01);
    chk(reg_rdata_o, exp);
  endtask
  task automatic end_sim();
    $display("Checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (6) @(negedge clk_i);
    rst_n_i = 1'b1;
    rd(8'h64, 8'h20);
    rd(8'h65, 8'h20);
    chk({4'h0, path_seen}, 8'h0c);
    chk(steer_o.pos_level_db, 8'h00);
    chk({5'h00, flags_seen}, 8'h00);
    for (int i = 0; i < 15; i++) begin
      wr(rows[i].addr, rows[i].wdata);
      rd(rows[i].addr, rows[i].rdata);
      chk({4'h0, path_seen}, {4'h0, rows[i].path});
      chk(steer_o.pos_level_db, rows[i].level_db);
      chk({5'h00, flags_seen}, {5'h00, rows[i].flags});
    end
    chk(source_route_o, 8'h21);
    chk(drive_level_o, 8'hf9);
    // Same-cycle write and read returns the old byte
    @(negedge clk_i);
    reg_wr_i = 1'b1;
    reg_rd_i = 1'b1;
    reg_addr_i = 8'h65;
    reg_wdata_i = 8'h2a;
    @(negedge clk_i);
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    chk(reg_rdata_o, 8'hf9);
    chk(drive_level_o, 8'h2a);
    // Reset in mid-run restores both bytes
    rst_n_i = 1'b0;
    @(negedge clk_i);
    rst_n_i = 1'b1;
    chk(source_route_o, 8'h20);
    chk(drive_level_o, 8'h20);
    chk(reg_rdata_o, 8'h00);
    chk({7'h00, reg_rvalid_o}, 8'h00);
    chk({4'h0, path_seen}, 8'h0c);
    chk(steer_o.pos_level_db, 8'h00);
    chk({5'h00, flags_seen}, 8'h00);
    end_sim();
  end
  // Watchdog: the tests need under 200 cycles
  initial begin
    #4000;
    err_total++;
    end_sim();
  end
endmodule // output_channel_one_config_regs_tb_top
`default_nettype wire
